// file: sff_status_top.sv
// status flag logic for a serial port with 16-byte tx and rx fifos
// assumes receiver, transmitter shifter and dma logic run on clk; only the rx pin is foreign
`timescale 1ns/10ps
module sff_status_top (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic standby,
  // register port
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rdata,
  // mode and timing
  input wire logic async_mode,
  input wire logic etu_tick,
  // transmit shifter
  input wire logic tx_take,
  output logic [7:0] tx_byte,
  output logic tx_load,
  // receiver
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_frame_err,
  input wire logic rx_parity_err,
  input wire logic rx_stop,
  input wire logic rx_line,
  // dma
  input wire logic dma_tx_wr,
  input wire logic [7:0] dma_tx_data,
  input wire logic dma_rx_rd,
  output logic [7:0] dma_rx_data,
  output logic dma_tx_req,
  output logic dma_rx_req
);
  // flag registers
  logic tx_low_flag_reg;
  logic tx_low_flag_next;
  logic line_break_flag_reg;
  logic line_break_flag_next;
  logic rx_fifo_full_flag_reg;
  logic rx_fifo_full_flag_next;
  logic rx_idle_ready_flag_reg;
  logic rx_idle_ready_flag_next;
  // read-as-one arming, order {tx low, break, rx full, ready}
  logic [3:0] arm_reg;
  logic [3:0] arm_next;
  logic [3:0] flag_vec;
  logic [3:0] wclr;
  // control and break tracking
  logic [7:0] fifo_control_reg;
  logic prev_frame_err_reg;
  logic break_hold_reg;
  logic break_hold_next;
  logic rx_line_meta_reg;
  logic rx_line_sync_reg;
  // output registers
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [7:0] tx_byte_reg;
  logic tx_load_reg;
  logic [7:0] dma_rx_data_reg;
  // decode
  logic st_wr;
  logic st_rd;
  logic ctl_wr;
  logic ctl_rd;
  logic cnt_rd;
  logic cpu_tx_wr;
  logic cpu_rx_rd;
  logic dma_tx_push;
  logic dma_rx_pop;
  // fifo wires
  logic tx_push;
  logic [7:0] tx_din;
  logic tx_pop;
  logic [7:0] tx_head;
  logic [4:0] tx_cnt;
  logic [4:0] tx_cnt_next;
  logic tx_full;
  logic tx_empty;
  logic rx_push;
  logic [9:0] rx_din;
  logic rx_pop;
  logic [9:0] rx_head;
  logic [4:0] rx_cnt;
  logic [4:0] rx_cnt_next;
  logic rx_full;
  logic rx_empty;
  // trigger levels and events
  logic [4:0] tx_trig;
  logic [4:0] rx_trig;
  logic frame_err_status;
  logic parity_err_status;
  logic break_set;
  logic zero_char;
  logic idle_timeout;
  logic [15:0] status_vec;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] offs);
    addr_hit = (a == offs);
  endfunction

  // register port decode
  assign st_wr = wr_en & addr_hit(addr, sff_pkg::ADDR_STATUS);
  assign st_rd = rd_en & addr_hit(addr, sff_pkg::ADDR_STATUS);
  assign ctl_wr = wr_en & addr_hit(addr, sff_pkg::ADDR_CONTROL);
  assign ctl_rd = rd_en & addr_hit(addr, sff_pkg::ADDR_CONTROL);
  assign cnt_rd = rd_en & addr_hit(addr, sff_pkg::ADDR_COUNT);
  assign cpu_tx_wr = wr_en & addr_hit(addr, sff_pkg::ADDR_TX_PORT);
  assign cpu_rx_rd = rd_en & addr_hit(addr, sff_pkg::ADDR_RX_PORT);

  // trigger selection from the control register
  assign tx_trig = sff_pkg::tx_trig_count({fifo_control_reg[sff_pkg::CTL_TX_TRIG_HI],
                                           fifo_control_reg[sff_pkg::CTL_TX_TRIG_LO]});
  assign rx_trig = sff_pkg::rx_trig_count({fifo_control_reg[sff_pkg::CTL_RX_TRIG_HI],
                                           fifo_control_reg[sff_pkg::CTL_RX_TRIG_LO]});

  // transmit side; the cpu wins a same-cycle collision and the dma write is lost
  assign dma_tx_push = dma_tx_wr & ~cpu_tx_wr & ~tx_full;
  assign tx_push = (cpu_tx_wr | dma_tx_wr) & ~tx_full;
  assign tx_din = cpu_tx_wr ? wdata[7:0] : dma_tx_data;
  assign tx_pop = tx_take & ~tx_empty & ~standby;
  assign tx_cnt_next = tx_cnt + {4'h0, tx_push & ~standby} - {4'h0, tx_pop};

  sff_fifo #(
    .WIDTH(8)
  ) u_tx_fifo (
    .clk(clk),
    .nrst(nrst),
    .flush(standby),
    .push(tx_push),
    .din(tx_din),
    .pop(tx_pop),
    .dout(tx_head),
    .count(tx_cnt),
    .full(tx_full),
    .empty(tx_empty)
  );

  // receive side; zero characters after a break are not stored, overruns are dropped
  assign zero_char = (rx_data == 8'h00);
  assign break_set = rx_valid & rx_frame_err & prev_frame_err_reg & zero_char;
  assign rx_push = rx_valid & ~(break_hold_reg & zero_char) & ~rx_full;
  assign rx_din = {rx_frame_err, rx_parity_err, rx_data};
  assign dma_rx_pop = dma_rx_rd & ~cpu_rx_rd & ~rx_empty;
  assign rx_pop = (cpu_rx_rd | dma_rx_rd) & ~rx_empty & ~standby;
  assign rx_cnt_next = rx_cnt + {4'h0, rx_push & ~standby} - {4'h0, rx_pop};

  sff_fifo #(
    .WIDTH(10)
  ) u_rx_fifo (
    .clk(clk),
    .nrst(nrst),
    .flush(standby),
    .push(rx_push),
    .din(rx_din),
    .pop(rx_pop),
    .dout(rx_head),
    .count(rx_cnt),
    .full(rx_full),
    .empty(rx_empty)
  );

  sff_idle_timer u_idle_timer (
    .clk(clk),
    .nrst(nrst),
    .clear(standby),
    .restart(rx_stop),
    .etu_tick(etu_tick),
    .timeout(idle_timeout)
  );

  // error bits track the head entry so they change as the fifo is read
  assign frame_err_status = ~rx_empty & rx_head[9];
  assign parity_err_status = ~rx_empty & async_mode & rx_head[8];

  // status word as software sees it
  assign status_vec = {10'h000, tx_low_flag_reg, line_break_flag_reg, frame_err_status,
                       parity_err_status, rx_fifo_full_flag_reg, rx_idle_ready_flag_reg};

  // clear-by-zero needs an earlier read of one; a written one does nothing
  assign flag_vec = {tx_low_flag_reg, line_break_flag_reg, rx_fifo_full_flag_reg,
                     rx_idle_ready_flag_reg};
  assign wclr[3] = st_wr & ~wdata[sff_pkg::BIT_TX_LOW] & arm_reg[3];
  assign wclr[2] = st_wr & ~wdata[sff_pkg::BIT_BREAK] & arm_reg[2];
  assign wclr[1] = st_wr & ~wdata[sff_pkg::BIT_RX_FULL] & arm_reg[1];
  assign wclr[0] = st_wr & ~wdata[sff_pkg::BIT_RX_READY] & arm_reg[0];
  assign arm_next = st_wr ? 4'h0 : ((arm_reg | (st_rd ? flag_vec : 4'h0)) & flag_vec);

  // tx low: set wins over either clear in the same cycle
  assign tx_low_flag_next = (tx_pop & (tx_cnt_next <= tx_trig))
                          | (tx_low_flag_reg
                             & ~(wclr[3] & (tx_cnt > tx_trig))
                             & ~(dma_tx_push & (tx_cnt_next > tx_trig)));

  // break: only software, reset or standby clears it
  assign line_break_flag_next = break_set | (line_break_flag_reg & ~wclr[2]);
  assign break_hold_next = break_set | (break_hold_reg & ~rx_line_sync_reg);

  // rx full follows the level, clears by software or dma draining
  assign rx_fifo_full_flag_next = (rx_cnt_next >= rx_trig)
                                | (rx_fifo_full_flag_reg
                                   & ~(wclr[1] & (rx_cnt < rx_trig))
                                   & ~(dma_rx_pop & (rx_cnt_next < rx_trig)));

  // ready: data left below trigger after an idle gap
  assign rx_idle_ready_flag_next = (idle_timeout & (rx_cnt != 5'h00) & (rx_cnt < rx_trig))
                                 | (rx_idle_ready_flag_reg & ~(wclr[0] & rx_empty));

  // read mux; unmapped and write-only offsets read as zero
  assign rdata_next = st_rd ? status_vec :
                      ctl_rd ? {8'h00, fifo_control_reg} :
                      cnt_rd ? {3'h0, tx_cnt, 3'h0, rx_cnt} :
                      cpu_rx_rd ? {8'h00, rx_head[7:0]} :
                      sff_pkg::RDATA_RST;

  // rx pin is foreign to clk; two stages before break-end logic reads it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_line_meta_reg <= 1'b1;
      rx_line_sync_reg <= 1'b1;
    end
    else
    begin
      rx_line_meta_reg <= rx_line;
      rx_line_sync_reg <= rx_line_meta_reg;
    end
  end

  // status flags; standby restores the reset state synchronously
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_low_flag_reg <= 1'b1;
      line_break_flag_reg <= 1'b0;
      rx_fifo_full_flag_reg <= 1'b0;
      rx_idle_ready_flag_reg <= 1'b0;
      arm_reg <= 4'h0;
      break_hold_reg <= 1'b0;
      prev_frame_err_reg <= 1'b0;
    end
    else if (standby)
    begin
      tx_low_flag_reg <= 1'b1;
      line_break_flag_reg <= 1'b0;
      rx_fifo_full_flag_reg <= 1'b0;
      rx_idle_ready_flag_reg <= 1'b0;
      arm_reg <= 4'h0;
      break_hold_reg <= 1'b0;
      prev_frame_err_reg <= 1'b0;
    end
    else
    begin
      tx_low_flag_reg <= tx_low_flag_next;
      line_break_flag_reg <= line_break_flag_next;
      rx_fifo_full_flag_reg <= rx_fifo_full_flag_next;
      rx_idle_ready_flag_reg <= rx_idle_ready_flag_next;
      arm_reg <= arm_next;
      break_hold_reg <= break_hold_next;
      if (rx_valid)
      begin
        prev_frame_err_reg <= rx_frame_err;
      end
    end
  end

  // control register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fifo_control_reg <= sff_pkg::CONTROL_RST;
    end
    else if (standby)
    begin
      fifo_control_reg <= sff_pkg::CONTROL_RST;
    end
    else if (ctl_wr)
    begin
      fifo_control_reg <= wdata[7:0];
    end
  end

  // registered outputs
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_reg <= sff_pkg::RDATA_RST;
      tx_byte_reg <= 8'h00;
      tx_load_reg <= 1'b0;
      dma_rx_data_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= rdata_next;
      tx_load_reg <= tx_pop;
      if (tx_pop)
      begin
        tx_byte_reg <= tx_head;
      end
      if (dma_rx_pop & ~standby)
      begin
        dma_rx_data_reg <= rx_head[7:0];
      end
    end
  end

  assign rdata = rdata_reg;
  assign tx_byte = tx_byte_reg;
  assign tx_load = tx_load_reg;
  assign dma_rx_data = dma_rx_data_reg;
  // dma requests mirror the level flags
  assign dma_tx_req = tx_low_flag_reg;
  assign dma_rx_req = rx_fifo_full_flag_reg;
endmodule

// file: sff_pkg.sv
// package for the serial fifo status flag block: offsets, fields, reset values, timing
// assumes one 200 MHz clock, a 16-bit register port and a bit-period tick from the rate logic
package sff_pkg;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned PTR_W = 4;
  localparam int unsigned CNT_W = 5;
  // register byte offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_TX_PORT = 8'h04;
  localparam logic [7:0] ADDR_RX_PORT = 8'h08;
  localparam logic [7:0] ADDR_CONTROL = 8'h0c;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  // status bit positions
  localparam int unsigned BIT_TX_LOW = 5;
  localparam int unsigned BIT_BREAK = 4;
  localparam int unsigned BIT_FRAME_ERR = 3;
  localparam int unsigned BIT_PARITY_ERR = 2;
  localparam int unsigned BIT_RX_FULL = 1;
  localparam int unsigned BIT_RX_READY = 0;
  // control bit positions
  localparam int unsigned CTL_TX_TRIG_LO = 4;
  localparam int unsigned CTL_TX_TRIG_HI = 5;
  localparam int unsigned CTL_RX_TRIG_LO = 6;
  localparam int unsigned CTL_RX_TRIG_HI = 7;
  // reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [15:0] RDATA_RST = 16'h0000;
  // trigger levels per selector code
  localparam logic [4:0] TX_TRIG_0 = 5'h08;
  localparam logic [4:0] TX_TRIG_1 = 5'h04;
  localparam logic [4:0] TX_TRIG_2 = 5'h02;
  localparam logic [4:0] TX_TRIG_3 = 5'h01;
  localparam logic [4:0] RX_TRIG_0 = 5'h01;
  localparam logic [4:0] RX_TRIG_1 = 5'h04;
  localparam logic [4:0] RX_TRIG_2 = 5'h08;
  localparam logic [4:0] RX_TRIG_3 = 5'h0e;
  // idle time in bit periods; counted on the bit tick, not on clk
  localparam logic [4:0] IDLE_ETU = 5'h10;

  function automatic logic [4:0] tx_trig_count(input logic [1:0] sel);
    case (sel)
      2'h0: tx_trig_count = TX_TRIG_0;
      2'h1: tx_trig_count = TX_TRIG_1;
      2'h2: tx_trig_count = TX_TRIG_2;
      default: tx_trig_count = TX_TRIG_3;
    endcase
  endfunction

  function automatic logic [4:0] rx_trig_count(input logic [1:0] sel);
    case (sel)
      2'h0: rx_trig_count = RX_TRIG_0;
      2'h1: rx_trig_count = RX_TRIG_1;
      2'h2: rx_trig_count = RX_TRIG_2;
      default: rx_trig_count = RX_TRIG_3;
    endcase
  endfunction
endpackage

// file: sff_fifo.sv
// synchronous 16-entry fifo with occupancy count and flush
// assumes the caller never pushes when full nor pops when empty; both are gated here too
`timescale 1ns/10ps
module sff_fifo #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic flush,
  // write side
  input wire logic push,
  input wire logic [WIDTH-1:0] din,
  // read side
  input wire logic pop,
  output logic [WIDTH-1:0] dout,
  // level
  output logic [sff_pkg::CNT_W-1:0] count,
  output logic full,
  output logic empty
);
  logic [WIDTH-1:0] mem [0:sff_pkg::FIFO_DEPTH-1];
  logic [sff_pkg::PTR_W-1:0] wr_ptr_reg;
  logic [sff_pkg::PTR_W-1:0] rd_ptr_reg;
  logic [sff_pkg::CNT_W-1:0] count_reg;
  logic do_push;
  logic do_pop;

  assign full = (count_reg == sff_pkg::CNT_W'(sff_pkg::FIFO_DEPTH));
  assign empty = (count_reg == '0);
  assign do_push = push & ~full & ~flush;
  assign do_pop = pop & ~empty & ~flush;
  // head shows stale storage when empty, which is the undefined read value
  assign dout = mem[rd_ptr_reg];
  assign count = count_reg;

  // storage needs no reset
  always_ff @(posedge clk)
  begin
    if (do_push)
    begin
      mem[wr_ptr_reg] <= din;
    end
  end

  // pointers and level
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else if (flush)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg + ptr_one(do_push);
      rd_ptr_reg <= rd_ptr_reg + ptr_one(do_pop);
      count_reg <= count_reg + {4'h0, do_push} - {4'h0, do_pop};
    end
  end

  function automatic logic [sff_pkg::PTR_W-1:0] ptr_one(input logic b);
    ptr_one = {3'h0, b};
  endfunction
endmodule

// file: sff_idle_timer.sv
// idle timer: counts bit periods after the last stop bit and pulses once on timeout
// assumes etu_tick is a one-cycle pulse per bit period from the rate logic on clk
`timescale 1ns/10ps
module sff_idle_timer (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic clear,
  // timing
  input wire logic restart,
  input wire logic etu_tick,
  output logic timeout
);
  logic [4:0] cnt_reg;
  logic run_reg;
  logic timeout_reg;
  logic last_tick;

  assign last_tick = run_reg & etu_tick & (cnt_reg == sff_pkg::IDLE_ETU - 5'h01);
  assign timeout = timeout_reg;

  // stops after one timeout so the ready flag sees a single event per idle gap
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_reg <= 5'h00;
      run_reg <= 1'b0;
      timeout_reg <= 1'b0;
    end
    else if (clear)
    begin
      cnt_reg <= 5'h00;
      run_reg <= 1'b0;
      timeout_reg <= 1'b0;
    end
    else
    begin
      timeout_reg <= last_tick & ~restart;
      if (restart)
      begin
        cnt_reg <= 5'h00;
        run_reg <= 1'b1;
      end
      else if (last_tick)
      begin
        run_reg <= 1'b0;
      end
      else if (run_reg & etu_tick)
      begin
        cnt_reg <= cnt_reg + 5'h01;
      end
    end
  end
endmodule

// file: sff_status_properties.sv
// concurrent checks on the status flag block, seen from its top ports only
// assumes one clock domain, asynchronous active-low reset and the flag mirrors on the dma requests
`timescale 1ns/10ps
module sff_status_properties (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic standby,
  // register port
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] rdata,
  // transmit shifter
  input wire logic tx_take,
  input wire logic [7:0] tx_byte,
  input wire logic tx_load,
  // receiver and dma
  input wire logic rx_valid,
  input wire logic dma_tx_wr,
  input wire logic dma_rx_rd,
  input wire logic [7:0] dma_rx_data,
  input wire logic dma_tx_req,
  input wire logic dma_rx_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // read data only in the cycle after a read strobe, so a stuck value cannot pass
  chk_rdata_quiet: assert property (!$past(rd_en) |-> rdata == 16'h0000)
    else $error("read data present without a read strobe");
  chk_load_cause: assert property (tx_load |-> $past(tx_take))
    else $error("byte handed to the shifter without a request");
  chk_byte_hold: assert property (!$past(tx_take) && !$past(standby) |-> $stable(tx_byte))
    else $error("transmit byte changed without a request");
  chk_standby_init: assert property (standby |=> dma_tx_req && !dma_rx_req)
    else $error("flags not in reset state after standby");
  // a flag may only move for a cause visible at the ports
  chk_full_rise: assert property ($rose(dma_rx_req) |-> $past(rx_valid) || $past(wr_en))
    else $error("receive full flag set without a stored character");
  chk_full_fall: assert property ($fell(dma_rx_req) |->
    $past(dma_rx_rd) || $past(wr_en) || $past(standby))
    else $error("receive full flag cleared without a read or flag write");
  chk_low_rise: assert property ($rose(dma_tx_req) |->
    $past(tx_take) || $past(wr_en) || $past(standby))
    else $error("transmit low flag set without a byte leaving");
  chk_low_fall: assert property ($fell(dma_tx_req) |-> $past(dma_tx_wr) || $past(wr_en))
    else $error("transmit low flag cleared without a write");
  chk_dma_hold: assert property (!$past(dma_rx_rd) && !$past(standby) |->
    $stable(dma_rx_data))
    else $error("dma receive byte changed without a dma read");
endmodule

bind sff_status_top sff_status_properties sff_status_properties_i (.clk(clk), .nrst(nrst),
  .standby(standby), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .tx_take(tx_take),
  .tx_byte(tx_byte), .tx_load(tx_load), .rx_valid(rx_valid), .dma_tx_wr(dma_tx_wr),
  .dma_rx_rd(dma_rx_rd), .dma_rx_data(dma_rx_data), .dma_tx_req(dma_tx_req),
  .dma_rx_req(dma_rx_req));

// file: sff_line_model.sv
// far side model: remote transmitter delivering characters and the shifter taking bytes
// assumes the bench calls its tasks hierarchically; all outputs change just after clk rises
`timescale 1ns/10ps
module sff_line_model (
  // clock
  input wire logic clk,
  // transmit shifter side
  input wire logic tx_load,
  input wire logic [7:0] tx_byte,
  output logic tx_take,
  // receiver side
  output logic etu_tick,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_frame_err,
  output logic rx_parity_err,
  output logic rx_stop,
  output logic rx_line
);
  logic [1:0] div;

  initial
  begin
    {tx_take, etu_tick, rx_valid, rx_frame_err, rx_parity_err, rx_stop} = 6'h00;
    rx_data = 8'h00;
    rx_line = 1'b1;
    div = 2'h0;
  end

  // bit period of four clocks; rate logic runs free between characters
  always @(posedge clk)
  begin
    div <= div + 2'h1;
    etu_tick <= (div == 2'h3);
  end

  // one character; qualifiers turn to junk afterwards so nothing stale is trusted
  task send_char(input logic [7:0] d, input logic fe, input logic pe);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= d;
    rx_frame_err <= fe;
    rx_parity_err <= pe;
    rx_stop <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_stop <= 1'b0;
    rx_data <= ~d;
    rx_frame_err <= ~fe;
    rx_parity_err <= ~pe;
  endtask

  // line level: space during a break, mark otherwise
  task set_line(input logic lvl);
    @(posedge clk);
    rx_line <= lvl;
  endtask

  task take(output logic [7:0] b, output logic ld);
    @(posedge clk);
    tx_take <= 1'b1;
    @(posedge clk);
    tx_take <= 1'b0;
    #1;
    ld = tx_load;
    b = tx_byte;
  endtask
endmodule

// file: test_serial_fifo_status_flags.sv
// self-checking bench for the status flag block: register port, dma, shifter and line model
// assumes the package offsets and trigger tables; status masks follow its bit positions
`timescale 1ns/10ps
module test_serial_fifo_status_flags;
  logic clk, nrst, standby, wr_en, rd_en, async_mode, dma_tx_wr, dma_rx_rd;
  logic [7:0] addr, dma_tx_data, tx_byte, rx_data, dma_rx_data, b;
  logic [15:0] wdata, rdata, v;
  logic tx_take, tx_load, rx_valid, rx_frame_err, rx_parity_err, rx_stop, rx_line;
  logic etu_tick, dma_tx_req, dma_rx_req, ld, ready;
  int fail_count, check_count, i, n;
  time t0;

  sff_status_top sff_status_top_i (.clk(clk), .nrst(nrst), .standby(standby), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .async_mode(async_mode),
    .etu_tick(etu_tick), .tx_take(tx_take), .tx_byte(tx_byte), .tx_load(tx_load),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_frame_err(rx_frame_err),
    .rx_parity_err(rx_parity_err), .rx_stop(rx_stop), .rx_line(rx_line),
    .dma_tx_wr(dma_tx_wr), .dma_tx_data(dma_tx_data), .dma_rx_rd(dma_rx_rd),
    .dma_rx_data(dma_rx_data), .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req));
  sff_line_model sff_line_model_i (.clk(clk), .tx_load(tx_load), .tx_byte(tx_byte),
    .tx_take(tx_take), .etu_tick(etu_tick), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_frame_err(rx_frame_err), .rx_parity_err(rx_parity_err), .rx_stop(rx_stop),
    .rx_line(rx_line));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task tally_and_finish;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // strobes live for one cycle; read data sampled in the cycle after the read edge
  task rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask

  task rchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    check(d, exp);
  endtask

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // one cycle pulse on a side-band input
  task pulse_dma(input logic tx_wr, input logic rx_rd);
    @(posedge clk);
    dma_tx_wr <= tx_wr;
    dma_tx_data <= 8'haa;
    dma_rx_rd <= rx_rd;
    @(posedge clk);
    {dma_tx_wr, dma_rx_rd} <= 2'h0;
    #1;
  endtask

  initial
  begin
    #100us;
    fail_count++;
    tally_and_finish;
  end

  initial
  begin
    {nrst, standby, wr_en, rd_en, dma_tx_wr, dma_rx_rd} = 6'h00;
    {addr, dma_tx_data, wdata} = 32'h0;
    async_mode = 1'b1;
    fail_count = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rchk(sff_pkg::ADDR_STATUS, 16'h0020);
    rchk(sff_pkg::ADDR_COUNT, 16'h0000);
    wr(sff_pkg::ADDR_STATUS, 16'h003f);
    rchk(sff_pkg::ADDR_STATUS, 16'h0020);
    wr(sff_pkg::ADDR_STATUS, 16'h0000);
    rchk(sff_pkg::ADDR_STATUS, 16'h0020);
    // seventeenth byte must be dropped
    for (i = 0; i < 17; i++) wr(sff_pkg::ADDR_TX_PORT, 16'(i + 1));
    rchk(sff_pkg::ADDR_COUNT, 16'h1000);
    wr(sff_pkg::ADDR_STATUS, 16'h0000);
    rchk(sff_pkg::ADDR_STATUS, 16'h0000);
    for (i = 0; i < 8; i++)
    begin
      sff_line_model_i.take(b, ld);
      check({7'h00, ld, b}, 16'h0100 | 16'(i + 1));
      if (i == 6) rchk(sff_pkg::ADDR_STATUS, 16'h0000);
    end
    rchk(sff_pkg::ADDR_STATUS, 16'h0020);
    pulse_dma(1'b1, 1'b0);
    rchk(sff_pkg::ADDR_STATUS, 16'h0000);
    check({15'h0000, dma_tx_req}, 16'h0000);
    for (i = 0; i < 9; i++)
    begin
      sff_line_model_i.take(b, ld);
      check({7'h00, ld, b}, 16'h0100 | ((i < 8) ? 16'(i + 9) : 16'h00aa));
    end
    sff_line_model_i.take(b, ld);
    check({15'h0000, ld}, 16'h0000);
    rchk(sff_pkg::ADDR_STATUS, 16'h0020);
    // receive trigger of four; head character errors shown in the status word
    wr(sff_pkg::ADDR_CONTROL, 16'h0040);
    sff_line_model_i.send_char(8'h31, 1'b1, 1'b0);
    sff_line_model_i.send_char(8'h32, 1'b0, 1'b1);
    sff_line_model_i.send_char(8'h33, 1'b0, 1'b0);
    rchk(sff_pkg::ADDR_COUNT, 16'h0003);
    rchk(sff_pkg::ADDR_STATUS, 16'h0028);
    sff_line_model_i.send_char(8'h34, 1'b0, 1'b0);
    rchk(sff_pkg::ADDR_STATUS, 16'h002a);
    check({15'h0000, dma_rx_req}, 16'h0001);
    pulse_dma(1'b0, 1'b1);
    check({8'h00, dma_rx_data}, 16'h0031);
    rchk(sff_pkg::ADDR_STATUS, 16'h0024);
    // outside asynchronous mode the parity bit of the head stays hidden
    @(posedge clk) async_mode <= 1'b0;
    rchk(sff_pkg::ADDR_STATUS, 16'h0020);
    @(posedge clk) async_mode <= 1'b1;
    sff_line_model_i.send_char(8'h35, 1'b0, 1'b0);
    t0 = $time;
    rchk(sff_pkg::ADDR_STATUS, 16'h0026);
    rchk(sff_pkg::ADDR_RX_PORT, 16'h0032);
    rchk(sff_pkg::ADDR_STATUS, 16'h0022);
    wr(sff_pkg::ADDR_STATUS, 16'h0000);
    rchk(sff_pkg::ADDR_STATUS, 16'h0020);
    // idle timeout: poll with a bound, then check it was not early
    ready = 1'b0;
    for (n = 0; n < 200 && ready !== 1'b1; n++)
    begin
      rd(sff_pkg::ADDR_STATUS, v);
      ready = v[0];
    end
    if (ready !== 1'b1)
    begin
      fail_count++;
      tally_and_finish;
    end
    check(v, 16'h0021);
    check({15'h0000, ($time - t0) >= 300}, 16'h0001);
    wr(sff_pkg::ADDR_STATUS, 16'h0000);
    rchk(sff_pkg::ADDR_STATUS, 16'h0021);
    for (i = 0; i < 3; i++) rchk(sff_pkg::ADDR_RX_PORT, 16'(8'h33 + i));
    rd(sff_pkg::ADDR_RX_PORT, v);
    rchk(sff_pkg::ADDR_COUNT, 16'h0000);
    wr(sff_pkg::ADDR_STATUS, 16'h0000);
    rchk(sff_pkg::ADDR_STATUS, 16'h0020);
    // standby then break: zero characters held back until the line is at mark
    @(posedge clk);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    rchk(sff_pkg::ADDR_STATUS, 16'h0020);
    rchk(sff_pkg::ADDR_COUNT, 16'h0000);
    sff_line_model_i.set_line(1'b0);
    sff_line_model_i.send_char(8'h55, 1'b1, 1'b0);
    sff_line_model_i.send_char(8'h00, 1'b1, 1'b0);
    wr(sff_pkg::ADDR_STATUS, 16'h0000);
    rchk(sff_pkg::ADDR_STATUS, 16'h003a);
    sff_line_model_i.send_char(8'h00, 1'b0, 1'b0);
    rchk(sff_pkg::ADDR_COUNT, 16'h0002);
    sff_line_model_i.set_line(1'b1);
    repeat (4) @(posedge clk);
    sff_line_model_i.send_char(8'h00, 1'b0, 1'b0);
    rchk(sff_pkg::ADDR_COUNT, 16'h0003);
    rchk(sff_pkg::ADDR_STATUS, 16'h003a);
    wr(sff_pkg::ADDR_STATUS, 16'h0000);
    rchk(sff_pkg::ADDR_STATUS, 16'h002a);
    tally_and_finish;
  end
endmodule
